// *** design/fifo_ctrl.sv ***
// Function
// [R1] Clear pulse resets both device pointers and all flags.
// [R2] Controller issues a clear after reset before any write; here it issues none and refuses writes, reads and replays until a user clear request.
// [R3] Chain input sampled during clear; low selects stand-alone.
// [R4] Write begins on load strobe fall with full high; data on rise.
// [R5] Filling last location drives full low after load strobe fall.
// [R6] While full low, writes ignored and stored data kept.
// [R7] Half flag low after word 1025 until count at half or less.
// [R8] Reading word 1025 returns half flag high after unload rise.
// [R9] First write to empty buffer raises empty high after load rise.
// [R10] In cascade, writing final location pulses chain output low.
// [R11] Read when unload falls with empty high; data valid access later.
// [R12] Reading last word drives empty low on unload fall.
// [R13] While empty low, reads ignored and outputs high impedance.
// [R14] Read while full returns full high after unload rise.
// [R15] In cascade, reading final location pulses chain output low.
// [R16] Replay low rewinds read pointer, write pointer unchanged.
// [R17] Replay only allowed with fewer than 2047 writes since clear.
// [R18] After replay release, wait recovery time before reading.
// [R19] After replay, flags recomputed from stored volume.
// [R20] First loader low on first device, high on all others; here replay_n stays high in cascade.
// [R21] Write and read ports operate independently and asynchronously.
// [R22] In cascade, half flag and replay are unavailable.
// [R23] Storage holds 2048 words; pointers wrap at final location.
`timescale 1ns/100ps
`include "fifo_ctrl_params.svh"

module fifo_ctrl
  import fifo_ctrl_pkg::*;
#(
  parameter int DATA_W = `DATA_W,
  parameter int CNT_W = `CNT_W
)(
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset
  input wire logic req_valid, // user request
  output logic req_ready, // request taken
  input wire op_kind_t req_op, // operation
  input wire logic [DATA_W-1:0] req_wdata, // write data
  output logic rsp_valid, // operation finished
  output logic rsp_ok, // operation performed
  output logic [DATA_W-1:0] rsp_rdata, // read data
  output dev_flags_t flags, // synchronised flags
  input wire logic cascade_mode, // device wired in chain
  output logic load_n, // device load strobe
  output logic unload_n, // device unload strobe
  output logic clear_pulse_n, // device clear
  output logic replay_n, // device replay
  output logic [DATA_W-1:0] dev_wdata, // device data in
  input wire logic [DATA_W-1:0] dev_rdata, // device data out
  input wire logic empty_flag_n, // device empty flag
  input wire logic full_flag_n, // device full flag
  input wire logic half_level_flag_n // device half flag
);

  // ----------------------------------------------------------------
  // flag synchronisers
  // ----------------------------------------------------------------
  dev_flags_t meta;
  dev_flags_t sync;

  // two stages, meta read only by sync
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta <= '{empty_n: 1'b0, full_n: 1'b1, half_n: 1'b1};
      sync <= '{empty_n: 1'b0, full_n: 1'b1, half_n: 1'b1};
    end
    else
    begin
      meta <= '{empty_n: empty_flag_n, full_n: full_flag_n,
                half_n: half_level_flag_n};
      sync <= meta;
    end
  end

  // half flag meaningless in a chain
  assign flags = '{empty_n: sync.empty_n, full_n: sync.full_n,
                   half_n: cascade_mode ? 1'b1 : sync.half_n}; // [R22]

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  ctrl_state_t state, next_state;
  op_kind_t op, next_op;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [11:0] wr_count, next_wr_count;
  logic cleared, next_cleared;
  logic ok, next_ok;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic [DATA_W-1:0] rdata, next_rdata;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n < 1 ? 1 : n);
  endfunction

  // pick whether a request may be performed now
  function automatic logic allowed(input op_kind_t k, input dev_flags_t f,
                                   input logic cl, input logic casc,
                                   input logic [11:0] wc);
    case (k)
      op_write: allowed = cl && f.full_n; // [R2] [R6]
      op_read: allowed = cl && f.empty_n; // [R13]
      // a chained part holds this pin as first loader, never pulse it [R20]
      op_replay: allowed = cl && !casc
                 && wc < 12'(`REPLAY_WRITE_LIMIT); // [R17] [R22]
      default: allowed = 1'b1;
    endcase
  endfunction

  assign req_ready = (state == st_idle);

  // next-state logic; one strobe at a time keeps timing simple
  always_comb
  begin
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    next_wr_count = wr_count;
    next_cleared = cleared;
    next_ok = ok;
    next_wdata = wdata;
    next_rdata = rdata;
    case (state)
      st_clear:
      begin
        next_state = st_idle;
      end
      st_idle:
      begin
        if (req_valid)
        begin
          next_op = req_op;
          next_wdata = req_wdata;
          next_ok = allowed(req_op, sync, cleared, cascade_mode, wr_count);
          next_cnt = cyc(`PULSE_CYC);
          next_state = next_ok ? st_pulse : st_done;
        end
      end
      st_pulse:
      begin
        next_cnt = cnt - 1'b1;
        if (cnt == 1)
        begin
          next_cnt = cyc(`RECOVERY_CYC + `RT_SETUP_CYC);
          next_state = st_recover;
          if (op == op_read)
            next_rdata = dev_rdata; // [R11] sampled after access time
          if (op == op_write)
            next_wr_count = (wr_count == 12'hfff) ? wr_count
                            : wr_count + 12'h001;
          if (op == op_clear)
          begin
            next_cleared = 1'b1; // [R1] [R3]
            next_wr_count = 12'h000;
          end
        end
      end
      st_recover:
      begin
        // replay recovery before next read [R18]
        next_cnt = cnt - 1'b1;
        if (cnt == 1)
          next_state = st_done;
      end
      st_done:
      begin
        next_state = st_idle;
      end
      default:
      begin
        next_state = st_clear;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= st_clear;
      op <= op_clear;
      cnt <= '0;
      wr_count <= 12'h000;
      cleared <= 1'b0;
      ok <= 1'b0;
      wdata <= '0;
      rdata <= '0;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      wr_count <= next_wr_count;
      cleared <= next_cleared;
      ok <= next_ok;
      wdata <= next_wdata;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers, registered to avoid glitches on strobes
  // ----------------------------------------------------------------
  logic next_load_n, next_unload_n, next_clear_n, next_replay_n;

  always_comb
  begin
    next_load_n = !(next_state == st_pulse && next_op == op_write); // [R4]
    next_unload_n = !(next_state == st_pulse
                      && next_op == op_read); // [R11] [R21]
    next_clear_n = !(next_state == st_pulse && next_op == op_clear);
    next_replay_n = !(next_state == st_pulse
                      && next_op == op_replay); // [R16]
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      load_n <= 1'b1;
      unload_n <= 1'b1;
      clear_pulse_n <= 1'b1;
      replay_n <= 1'b1;
      dev_wdata <= '0;
    end
    else
    begin
      load_n <= next_load_n;
      unload_n <= next_unload_n;
      clear_pulse_n <= next_clear_n;
      replay_n <= next_replay_n;
      dev_wdata <= next_wdata; // held across the load rise [R4]
    end
  end

  assign rsp_valid = (state == st_done);
  assign rsp_ok = ok;
  assign rsp_rdata = rdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence load_low;
    !load_n;
  endsequence

  a_write_needs_clear: assert property (load_low |-> cleared) // [R2]
    else $error("write before clear");
  // the flag view one edge back is the one the decision used
  a_write_full: assert property ($fell(load_n) // [R6]
                                 |-> $past(sync.full_n))
    else $error("write while full");
  a_read_empty: assert property ($fell(unload_n) // [R13]
                                 |-> $past(sync.empty_n))
    else $error("read while empty");
  a_replay_cascade: assert property (!replay_n |-> !cascade_mode) // [R22]
    else $error("replay in cascade");
  a_replay_limit: assert property ($fell(replay_n) // [R17]
                  |-> wr_count < 12'(`REPLAY_WRITE_LIMIT))
    else $error("replay beyond write limit");
  a_one_strobe: assert property ($onehot0({!load_n, !unload_n, // [R21]
                  !clear_pulse_n, !replay_n}))
    else $error("two strobes at once");
  a_pulse_width: assert property ($fell(load_n) |-> !load_n [*2]) // [R4]
    else $error("load pulse too short");
  a_replay_recover: assert property ($rose(replay_n) // [R18]
                    |-> unload_n [*2])
    else $error("read too soon after replay");

endmodule

// *** design/fifo_ctrl_params.svh ***
`ifndef FIFO_CTRL_PARAMS_SVH
`define FIFO_CTRL_PARAMS_SVH

// ----------------------------------------------------------------
// strobe and cycle timing, in ns and derived clock cycles
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define PULSE_NS 35
`define RECOVERY_NS 12
`define ACCESS_NS 35
`define RT_SETUP_NS 35
`define PULSE_CYC ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVERY_CYC ((`RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RT_SETUP_CYC ((`RT_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// buffer geometry
// ----------------------------------------------------------------
`define FIFO_DEPTH 2048
`define REPLAY_WRITE_LIMIT 2047
`define DATA_W 9
`define CNT_W 8

`endif

// *** design/fifo_ctrl_pkg.sv ***
`include "fifo_ctrl_params.svh"

package fifo_ctrl_pkg;

  // controller sequencer states, one-hot
  typedef enum logic [5:0] {
    st_clear   = 6'h01,
    st_idle    = 6'h02,
    st_pulse   = 6'h04,
    st_recover = 6'h08,
    st_done    = 6'h10,
    st_wait    = 6'h20
  } ctrl_state_t;

  // kinds of operation the user may ask for
  typedef enum logic [1:0] {
    op_write  = 2'h0,
    op_read   = 2'h1,
    op_replay = 2'h2,
    op_clear  = 2'h3
  } op_kind_t;

  // synchronised device flags
  typedef struct packed {
    logic empty_n;
    logic full_n;
    logic half_n;
  } dev_flags_t;

endpackage

// *** tb/fifo_dev_model.sv ***
`timescale 1ns/100ps
`include "fifo_ctrl_params.svh"

module fifo_dev_model
  import fifo_ctrl_pkg::*;
(
  input wire logic load_n, // load strobe
  input wire logic unload_n, // unload strobe
  input wire logic clear_pulse_n, // clear
  input wire logic replay_n, // replay
  input wire logic chain_in_n, // chain input, high when chained
  input wire logic [`DATA_W-1:0] dev_wdata, // data in
  output logic [`DATA_W-1:0] dev_rdata, // data out
  output logic empty_flag_n, // empty flag
  output logic full_flag_n, // full flag
  output logic half_level_flag_n // half flag
);
  // ------------------------------------------------------------
  // behavioural buffer, stand-alone or chained, strobe driven
  // ------------------------------------------------------------
  logic [`DATA_W-1:0] mem [0:`FIFO_DEPTH-1];
  logic [`DATA_W-1:0] word = 9'h000;
  logic [11:0] count = 12'h000;
  logic [11:0] nwr = 12'h000;
  logic [10:0] wptr = 11'h000;
  logic [10:0] rptr = 11'h000;
  logic wacc = 0;
  logic racc = 0;
  logic qvalid = 0;
  // chained parts reuse the half pin as chain output
  logic chained = 0;
  initial
  begin
    empty_flag_n = 0;
    full_flag_n = 1;
    half_level_flag_n = 1;
  end
  // floating outputs show the inverse, so stale data never passes
  assign dev_rdata = qvalid ? word : ~word;
  // clear puts pointers and flags back to the start
  always @(negedge clear_pulse_n)
  begin
    chained = chain_in_n;
    wptr = 0;
    rptr = 0;
    count = 0;
    nwr = 0;
    empty_flag_n = 0;
    full_flag_n = 1;
    half_level_flag_n = 1;
  end
  // write port, its own processes apart from the read port
  always @(negedge load_n)
  begin
    wacc = full_flag_n;
    if (wacc)
    begin
      count = count + 1;
      if (count == 12'd2048) full_flag_n = 0;
      if (count == 12'd1025 && !chained) half_level_flag_n = 0;
      if (chained && wptr == 11'h7ff) half_level_flag_n = 0;
    end
  end
  always @(posedge load_n)
    if (wacc)
    begin
      mem[wptr] = dev_wdata;
      wptr = wptr + 1;
      nwr = nwr + 1;
      empty_flag_n = 1;
      if (chained) half_level_flag_n = 1;
      wacc = 0;
    end
  // read port; data turns valid one access time after the fall
  always @(negedge unload_n)
  begin
    racc = empty_flag_n;
    if (racc)
    begin
      word = mem[rptr];
      if (chained && rptr == 11'h7ff) half_level_flag_n = 0;
      rptr = rptr + 1;
      count = count - 1;
      if (count == 12'd0) empty_flag_n = 0;
      #(`ACCESS_NS) qvalid = 1;
    end
  end
  always @(posedge unload_n)
    if (racc)
    begin
      qvalid = 0;
      full_flag_n = 1;
      if (chained || count <= 12'd1024) half_level_flag_n = 1;
      racc = 0;
    end
  // replay rewinds reads only; flags follow the stored volume
  always @(negedge replay_n)
  begin
    rptr = 0;
    count = nwr;
    empty_flag_n = (nwr != 0);
    full_flag_n = (nwr < 12'd2048);
    half_level_flag_n = (nwr <= 12'd1024);
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/100ps

module tb;
  import fifo_ctrl_pkg::*;
  typedef struct {logic ok; logic rd; logic [8:0] data;} exp_t;
  exp_t notes [$];
  logic [8:0] stored [$];
  logic [8:0] hist [$];
  logic clk_sys = 0;
  logic reset_n = 0;
  logic req_valid = 0;
  logic cascade_mode = 0;
  op_kind_t req_op = op_write;
  logic [8:0] req_wdata = 9'h000;
  logic req_ready, rsp_valid, rsp_ok, load_n, unload_n;
  logic clear_pulse_n, replay_n, empty_flag_n, full_flag_n;
  logic half_level_flag_n;
  logic [8:0] rsp_rdata, dev_wdata, dev_rdata;
  dev_flags_t flags;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int chain_pulses = 0;
  always #10 clk_sys = ~clk_sys;
  fifo_ctrl i_fifo_ctrl (.clk_sys, .reset_n, .req_valid, .req_ready,
    .req_op, .req_wdata, .rsp_valid, .rsp_ok, .rsp_rdata, .flags,
    .cascade_mode, .load_n, .unload_n, .clear_pulse_n, .replay_n,
    .dev_wdata, .dev_rdata, .empty_flag_n, .full_flag_n,
    .half_level_flag_n);
  fifo_dev_model i_fifo_dev_model (.load_n, .unload_n, .clear_pulse_n,
    .replay_n, .chain_in_n(cascade_mode), .dev_wdata, .dev_rdata,
    .empty_flag_n, .full_flag_n, .half_level_flag_n);
  // a chained part pulses its shared half pin at its final locations
  always @(negedge half_level_flag_n)
    if (cascade_mode) chain_pulses++;
  // ------------------------------------------------------------
  // comparison, reporting and the hang guard
  // ------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    check(9'(notes.size()), 9'h000);
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    // about 58k cycles expected; a hang ends here as a failure
    if (cycles == 75000)
    begin
      miscompares++;
      results();
    end
  end
  // watcher takes the oldest note whenever an answer shows
  always @(negedge clk_sys)
    if (rsp_valid === 1'b1 && notes.size() > 0)
    begin
      exp_t e;
      e = notes.pop_front();
      check({8'h00, rsp_ok}, {8'h00, e.ok});
      if (e.ok && e.rd) check(rsp_rdata, e.data);
    end
  // ------------------------------------------------------------
  // request driver; holds the request until it is taken
  // ------------------------------------------------------------
  task automatic op(input op_kind_t k, input logic [8:0] d,
                    input logic ok);
    int n;
    exp_t e;
    e.ok = ok;
    e.rd = (k == op_read);
    e.data = 9'h000;
    if (ok && k == op_write) stored.push_back(d);
    if (ok && k == op_write) hist.push_back(d);
    if (ok && k == op_clear) stored.delete();
    if (ok && k == op_clear) hist.delete();
    if (ok && k == op_replay) stored = hist;
    if (ok && e.rd) e.data = stored.pop_front();
    notes.push_back(e);
    @(negedge clk_sys);
    req_valid = 1;
    req_op = k;
    req_wdata = d;
    for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge clk_sys);
    @(negedge clk_sys);
    req_valid = 0;
    for (n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(negedge clk_sys);
    check({8'h00, rsp_valid}, 9'h001);
  endtask
  task automatic flag_is(input logic [2:0] f);
    @(negedge clk_sys);
    check({6'h00, flags}, {6'h00, f});
  endtask
  initial
  begin
    void'($urandom(57102));
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) reset_n = 1;
    op(op_write, 9'h055, 0);
    op(op_read, 9'h000, 0);
    $display("test before_clear done");
    op(op_clear, 9'h000, 1);
    flag_is(3'b011);
    repeat (5) op(op_write, 9'($urandom), 1);
    flag_is(3'b111);
    repeat (5) op(op_read, 9'h000, 1);
    flag_is(3'b011);
    op(op_read, 9'h000, 0);
    repeat (3) op(op_write, 9'($urandom), 1);
    repeat (3) op(op_read, 9'h000, 1);
    op(op_replay, 9'h000, 1);
    flag_is(3'b111);
    repeat (8) op(op_read, 9'h000, 1);
    $display("test short_and_replay done");
    op(op_clear, 9'h000, 1);
    for (int i = 0; i < 2048; i++)
    begin
      op(op_write, 9'($urandom), 1);
      if (i == 1023) flag_is(3'b111);
      if (i == 1024) flag_is(3'b110);
    end
    flag_is(3'b100);
    op(op_write, 9'($urandom), 0);
    op(op_replay, 9'h000, 0);
    op(op_read, 9'h000, 1);
    flag_is(3'b110);
    op(op_write, 9'($urandom), 1);
    flag_is(3'b100);
    while (stored.size() > 0)
    begin
      op(op_read, 9'h000, 1);
      if (stored.size() == 1025) flag_is(3'b110);
      if (stored.size() == 1024) flag_is(3'b111);
    end
    flag_is(3'b011);
    $display("test fill_and_drain done");
    cascade_mode = 1;
    op(op_clear, 9'h000, 1);
    op(op_write, 9'($urandom), 1);
    op(op_replay, 9'h000, 0);
    flag_is(3'b111);
    op(op_read, 9'h000, 1);
    repeat (2048) op(op_write, 9'($urandom), 1);
    flag_is(3'b101);
    check(9'(chain_pulses), 9'h001);
    while (stored.size() > 0) op(op_read, 9'h000, 1);
    check(9'(chain_pulses), 9'h002);
    flag_is(3'b011);
    $display("test cascade done");
    // let the watcher take the last note first
    @(negedge clk_sys);
    results();
  end
endmodule
